// ==== design/cmd_inject_defs.svh ====
`ifndef CMD_INJECT_DEFS_SVH
`define CMD_INJECT_DEFS_SVH
// Clock rate
`define CLK_MHZ 100
// Carrier half period in ns (500 kHz carrier)
`define CARRIER_HALF_NS 1000
`define CARRIER_HALF_CYC ((`CARRIER_HALF_NS * `CLK_MHZ) / 1000)
// Strobe period in ns (1 MHz) and its skew from carrier edges
`define STROBE_NS 1000
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ) / 1000)
`define STROBE_SKEW_NS 800
`define STROBE_SKEW_CYC ((`STROBE_SKEW_NS * `CLK_MHZ) / 1000)
// Endpoint clock half period (5 MHz)
`define EP_HALF_NS 100
`define EP_HALF_CYC ((`EP_HALF_NS * `CLK_MHZ) / 1000)
// Microsecond tick
`define US_CYC `CLK_MHZ
// Remote endpoint cycle figures, microseconds
`define REQ_A_US 16000
`define REQ_B_US 20000
`define CYCLE_US 54200
// Timeout counter taps and second counter thresholds
`define TO_STAGES 14
`define LAMP_TAP 4
`define CARRY_TAP 12
`define WARN_COUNT 4'h7
`define REVERT_COUNT 4'h8
// Tone length in microseconds
`define TONE_US 300000
// Activity one-shot length in microseconds
`define LAMP_US 200000
// Request character length in endpoint shift bits
`define REQ_BITS 8
`endif

// ==== design/cmd_inject_pkg.sv ====
package cmd_inject_pkg;
  // Routing of the relay buffer command input
  typedef enum logic [1:0] {
    ROUTE_UPSTREAM,
    ROUTE_INJECT,
    ROUTE_HOST
  } route_type;
endpackage : cmd_inject_pkg

// ==== design/command_injector_output_mode_timeout.sv ====
`timescale 1ns/10ps
`include "cmd_inject_defs.svh"
module command_injector_output_mode_timeout #(
  parameter int TONE_CYC = `TONE_US * `US_CYC,
  parameter int LAMP_CYC = `LAMP_US * `US_CYC,
  parameter int US_PER_TICK = `US_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_nrz_i,
  input wire logic inject_busy_i,
  input wire logic mode_switch_i,
  input wire logic host_ground_n_i,
  input wire logic upstream_cmd_i,
  input wire logic monitor_data_i,
  input wire logic cycle_tick_i,
  input wire logic cycle_start_pulse_i,
  input wire logic slow_rate_n_i,
  output logic phase_flip_code_o,
  output logic inject_sw_en_n_o,
  output logic upstream_sw_en_n_o,
  output logic inject_lamp_o,
  output logic monitor_lamp_o,
  output logic upstream_command_lamp_o,
  output logic mode_lamp_o,
  output logic warn_tone_o,
  output logic revert_tone_o,
  output logic endpoint_cmd_o,
  output logic endpoint_clk_o,
  output logic time_base_clear_o
);
  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (TONE_CYC < 1 || LAMP_CYC < 1 || US_PER_TICK < 1) begin
      $error("Counts must be at least one cycle");
    end
  end

  // ****************************************
  // Carrier, strobe and endpoint clock
  // ****************************************
  // Carrier divider; strobe phase skewed so sampling avoids carrier edges
  logic [7:0] car_cnt_r, car_cnt_nxt;
  logic carrier_r, carrier_nxt;
  logic [7:0] stb_cnt_r, stb_cnt_nxt;
  logic strobe;
  logic [3:0] ep_cnt_r, ep_cnt_nxt;
  logic ep_clk_r, ep_clk_nxt;
  logic code_r, code_nxt;
  logic coded;

  always_comb begin
    car_cnt_nxt = car_cnt_r + 8'h01;
    carrier_nxt = carrier_r;
    if (car_cnt_r == 8'(`CARRIER_HALF_CYC - 1)) begin
      car_cnt_nxt = 8'h00;
      carrier_nxt = ~carrier_r;
    end
    stb_cnt_nxt = (stb_cnt_r == 8'(`STROBE_CYC - 1)) ? 8'h00 : stb_cnt_r + 8'h01;
    ep_cnt_nxt = ep_cnt_r + 4'h1;
    ep_clk_nxt = ep_clk_r;
    if (ep_cnt_r == 4'(`EP_HALF_CYC - 1)) begin
      ep_cnt_nxt = 4'h0;
      ep_clk_nxt = ~ep_clk_r;
    end
  end

  // Strobe fires skew cycles after each carrier edge-aligned period start
  assign strobe = (stb_cnt_r == 8'(`STROBE_SKEW_CYC));
  // One bit inverts phase, zero keeps it
  assign coded = cmd_nrz_i ^ carrier_r;

  always_comb begin
    code_nxt = code_r;
    if (strobe) begin
      code_nxt = coded;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      car_cnt_r <= 8'h00;
      carrier_r <= 1'b0;
      stb_cnt_r <= 8'h00;
      ep_cnt_r <= 4'h0;
      ep_clk_r <= 1'b0;
      code_r <= 1'b0;
    end else begin
      car_cnt_r <= car_cnt_nxt;
      carrier_r <= carrier_nxt;
      stb_cnt_r <= stb_cnt_nxt;
      ep_cnt_r <= ep_cnt_nxt;
      ep_clk_r <= ep_clk_nxt;
      code_r <= code_nxt;
    end
  end

  // ****************************************
  // Mode and timeout
  // ****************************************
  logic inject_r, inject_nxt;
  logic sw_d_r, sw_d_nxt;
  logic [`TO_STAGES-1:0] to_cnt_r, to_cnt_nxt;
  logic [3:0] sec_cnt_r, sec_cnt_nxt;
  logic carry_d_r, carry_d_nxt;
  logic entering;
  logic revert;

  // Switch edge sets mode; holding switch does not rearm after timeout
  assign entering = mode_switch_i & ~sw_d_r & ~inject_r;
  assign revert = inject_r & (sec_cnt_r == `REVERT_COUNT);

  always_comb begin
    inject_nxt = inject_r;
    to_cnt_nxt = to_cnt_r;
    sec_cnt_nxt = sec_cnt_r;
    carry_d_nxt = to_cnt_r[`CARRY_TAP];
    sw_d_nxt = mode_switch_i;
    if (entering) begin
      inject_nxt = 1'b1;
      to_cnt_nxt = '0;
      sec_cnt_nxt = 4'h0;
    end else if (revert) begin
      inject_nxt = 1'b0;
      sec_cnt_nxt = 4'h0;
    end else if (inject_r) begin
      if (cycle_tick_i) begin
        to_cnt_nxt = to_cnt_r + 1'b1;
      end
      if (to_cnt_r[`CARRY_TAP] & ~carry_d_r) begin
        sec_cnt_nxt = sec_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inject_r <= 1'b0;
      sw_d_r <= 1'b0;
      to_cnt_r <= '0;
      sec_cnt_r <= 4'h0;
      carry_d_r <= 1'b0;
    end else begin
      inject_r <= inject_nxt;
      sw_d_r <= sw_d_nxt;
      to_cnt_r <= to_cnt_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      carry_d_r <= carry_d_nxt;
    end
  end

  // ****************************************
  // Routing
  // ****************************************
  // Host ground pre-empts both sources
  function automatic cmd_inject_pkg::route_type route_of(input logic inj, input logic host_n);
    if (!host_n) begin
      route_of = cmd_inject_pkg::ROUTE_HOST;
    end else if (inj) begin
      route_of = cmd_inject_pkg::ROUTE_INJECT;
    end else begin
      route_of = cmd_inject_pkg::ROUTE_UPSTREAM;
    end
  endfunction : route_of

  cmd_inject_pkg::route_type route;
  assign route = route_of(inject_nxt, host_ground_n_i);

  // ****************************************
  // One-shots, tones and lamps
  // ****************************************
  localparam int NSHOT = 5;
  logic [NSHOT-1:0] trig;
  logic [NSHOT-1:0] watch;
  logic [NSHOT-1:0] watch_d_r;
  logic [NSHOT-1:0] shot_on;

  assign watch = {revert, sec_cnt_r == `WARN_COUNT, monitor_data_i, upstream_cmd_i, inject_busy_i & inject_r};
  // Lamps retrigger on any edge; tones fire on rising edge only
  assign trig[0] = watch[0] ^ watch_d_r[0];
  assign trig[1] = watch[1] ^ watch_d_r[1];
  assign trig[2] = watch[2] ^ watch_d_r[2];
  assign trig[3] = watch[3] & ~watch_d_r[3];
  assign trig[4] = watch[4] & ~watch_d_r[4];

  // Previous watched levels; without them no edge could ever be seen
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watch_d_r <= '0;
    end else begin
      watch_d_r <= watch;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSHOT; g++) begin : g_shot
      localparam int LEN = (g < 3) ? LAMP_CYC : TONE_CYC;
      logic [31:0] cnt_r, cnt_nxt;
      always_comb begin
        cnt_nxt = (cnt_r != 32'h0000_0000) ? cnt_r - 32'h0000_0001 : cnt_r;
        if (trig[g]) begin
          cnt_nxt = 32'(LEN);
        end
      end
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cnt_r <= 32'h0000_0000;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
      assign shot_on[g] = (cnt_nxt != 32'h0000_0000);
    end
  endgenerate

  // ****************************************
  // Remote endpoint cycle and requests
  // ****************************************
  logic [7:0] us_cnt_r, us_cnt_nxt;
  logic [15:0] cyc_us_r, cyc_us_nxt;
  logic [3:0] req_cnt_r, req_cnt_nxt;
  logic [5:0] bit_div_r, bit_div_nxt;
  logic restart;
  logic req_start;

  // 200 kHz endpoint bit rate: 500 cycles, counted as us ticks of 5
  assign restart = ~slow_rate_n_i & (cyc_us_r == 16'(`CYCLE_US));
  assign req_start = ~slow_rate_n_i & (us_cnt_r == 8'h00) &
                     ((cyc_us_r == 16'(`REQ_A_US)) | (cyc_us_r == 16'(`REQ_B_US)));

  always_comb begin
    us_cnt_nxt = (us_cnt_r == 8'(US_PER_TICK - 1)) ? 8'h00 : us_cnt_r + 8'h01;
    cyc_us_nxt = cyc_us_r;
    if (us_cnt_r == 8'(US_PER_TICK - 1)) begin
      cyc_us_nxt = cyc_us_r + 16'h0001;
    end
    if (cycle_start_pulse_i | restart) begin
      us_cnt_nxt = 8'h00;
      cyc_us_nxt = 16'h0000;
    end
    req_cnt_nxt = req_cnt_r;
    bit_div_nxt = bit_div_r;
    if (req_start) begin
      req_cnt_nxt = 4'(`REQ_BITS);
      bit_div_nxt = 6'h00;
    end else if (req_cnt_r != 4'h0 && us_cnt_r == 8'h00) begin
      bit_div_nxt = (bit_div_r == 6'h04) ? 6'h00 : bit_div_r + 6'h01;
      if (bit_div_r == 6'h04) begin
        req_cnt_nxt = req_cnt_r - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      us_cnt_r <= 8'h00;
      cyc_us_r <= 16'h0000;
      req_cnt_r <= 4'h0;
      bit_div_r <= 6'h00;
    end else begin
      us_cnt_r <= us_cnt_nxt;
      cyc_us_r <= cyc_us_nxt;
      req_cnt_r <= req_cnt_nxt;
      bit_div_r <= bit_div_nxt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_flip_code_o <= 1'b0;
      inject_sw_en_n_o <= 1'b1;
      upstream_sw_en_n_o <= 1'b0;
      inject_lamp_o <= 1'b0;
      monitor_lamp_o <= 1'b0;
      upstream_command_lamp_o <= 1'b0;
      mode_lamp_o <= 1'b0;
      warn_tone_o <= 1'b0;
      revert_tone_o <= 1'b0;
      endpoint_cmd_o <= 1'b0;
      endpoint_clk_o <= 1'b0;
      time_base_clear_o <= 1'b0;
    end else begin
      phase_flip_code_o <= code_nxt;
      inject_sw_en_n_o <= (route != cmd_inject_pkg::ROUTE_INJECT);
      upstream_sw_en_n_o <= (route != cmd_inject_pkg::ROUTE_UPSTREAM);
      inject_lamp_o <= shot_on[0];
      upstream_command_lamp_o <= shot_on[1];
      monitor_lamp_o <= shot_on[2];
      warn_tone_o <= shot_on[3];
      revert_tone_o <= shot_on[4];
      mode_lamp_o <= inject_nxt & to_cnt_nxt[`LAMP_TAP];
      endpoint_cmd_o <= cmd_nrz_i | (req_cnt_nxt != 4'h0);
      endpoint_clk_o <= ep_clk_nxt;
      time_base_clear_o <= restart | cycle_start_pulse_i;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_host_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      !host_ground_n_i |=> (inject_sw_en_n_o && upstream_sw_en_n_o);
  endproperty
  a_host_off: assert property (p_host_off) else $error("Host ground did not free both switches");
  property p_exclusive;
    @(posedge core_clk_i) disable iff (!rst_n_i) inject_sw_en_n_o || upstream_sw_en_n_o;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("Both sources enabled");
  property p_revert;
    @(posedge core_clk_i) disable iff (!rst_n_i) revert |=> !inject_r ##1 revert_tone_o;
  endproperty
  a_revert: assert property (p_revert) else $error("Timeout did not revert with tone");
  property p_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i) entering |=> (to_cnt_r == '0 && sec_cnt_r == 4'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("Timeout not cleared on entry");
  property p_sample;
    @(posedge core_clk_i) disable iff (!rst_n_i) !strobe |=> $stable(code_r);
  endproperty
  a_sample: assert property (p_sample) else $error("Coded output moved off strobe");
  property p_warn;
    @(posedge core_clk_i) disable iff (!rst_n_i) $rose(sec_cnt_r == `WARN_COUNT) |-> ##2 warn_tone_o;
  endproperty
  a_warn: assert property (p_warn) else $error("Warning tone missing");
  property p_or;
    @(posedge core_clk_i) disable iff (!rst_n_i) cmd_nrz_i |=> endpoint_cmd_o;
  endproperty
  a_or: assert property (p_or) else $error("Command not merged onto endpoint input");
  property p_eclk;
    @(posedge core_clk_i) disable iff (!rst_n_i) $rose(ep_clk_r) |-> ##10 $fell(ep_clk_r);
  endproperty
  a_eclk: assert property (p_eclk) else $error("Endpoint clock period wrong");
endmodule : command_injector_output_mode_timeout

// ==== verif/relay_partner.sv ====
`timescale 1ns/10ps
// ****************************************
// Relay buffer and maintenance host model
// ****************************************
module relay_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic inject_sw_en_n_i,
  input wire logic upstream_sw_en_n_i,
  input wire logic host_ground_n_i,
  input wire logic monitor_on_i,
  output logic monitor_o,
  output logic contention_o
);
  logic [3:0] div_r; // Monitor bit pacing
  logic host_d_r; // Host ground as the switches last saw it
  // Two sources fighting on the buffer input, or a source beside the host
  // Host side is delayed one edge because the enables are registered
  assign contention_o = (!inject_sw_en_n_i && !upstream_sw_en_n_i) ||
    (!host_d_r && !(inject_sw_en_n_i && upstream_sw_en_n_i));
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_d_r <= 1'b1;
    end else begin
      host_d_r <= host_ground_n_i;
    end
  end
  // Monitor stream toggles every 16 cycles; an idle line rests low
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 4'h0;
      monitor_o <= 1'b0;
    end else if (!monitor_on_i) begin
      div_r <= 4'h0;
      monitor_o <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      if (div_r == 4'hf) begin
        monitor_o <= !monitor_o;
      end
    end
  end
endmodule : relay_partner

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
// ****************************************
// Injector output bench
// ****************************************
module testbench;
  logic clk = 1'b0; // 100 MHz
  logic rst_n, cmd_nrz, busy, mode_sw, gnd_n, up_cmd, tick, start, slow_n, mon_on;
  wire code, inj_n, up_n, inj_lamp, mon_lamp, up_lamp, mode_lamp, warn, revert, ep_cmd, ep_clk, mon, fight, tbc;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic v;
  // Rows: enter inject, host ground, expected inject and upstream enables
  logic [3:0] rows [4] = '{4'b0110, 4'b0011, 4'b1101, 4'b1011};
  always #5 clk = ~clk;
  // Short one-shots and microseconds keep the run brief
  command_injector_output_mode_timeout #(.TONE_CYC(50), .LAMP_CYC(50), .US_PER_TICK(2)) i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .cmd_nrz_i(cmd_nrz), .inject_busy_i(busy),
    .mode_switch_i(mode_sw), .host_ground_n_i(gnd_n), .upstream_cmd_i(up_cmd),
    .monitor_data_i(mon), .cycle_tick_i(tick), .cycle_start_pulse_i(start),
    .slow_rate_n_i(slow_n), .phase_flip_code_o(code), .inject_sw_en_n_o(inj_n),
    .upstream_sw_en_n_o(up_n), .inject_lamp_o(inj_lamp), .monitor_lamp_o(mon_lamp),
    .upstream_command_lamp_o(up_lamp), .mode_lamp_o(mode_lamp), .warn_tone_o(warn),
    .revert_tone_o(revert), .endpoint_cmd_o(ep_cmd), .endpoint_clk_o(ep_clk), .time_base_clear_o(tbc));
  relay_partner i_partner (.clk_i(clk), .rst_n_i(rst_n), .inject_sw_en_n_i(inj_n),
    .upstream_sw_en_n_i(up_n), .host_ground_n_i(gnd_n), .monitor_on_i(mon_on),
    .monitor_o(mon), .contention_o(fight));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  // Counts are bench integers, so a window is enough
  task automatic check_num(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_num
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task end_sim;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Fighting sources are never acceptable once out of reset
  always @(negedge clk) begin
    if (rst_n && fight === 1'b1) begin
      miscompares++;
      $display("[FAIL] source contention expected 0 seen 1");
    end
  end
  // Watchdog well beyond the longest wait
  initial begin
    #1_000_000;
    miscompares++;
    end_sim;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, cmd_nrz, busy, mode_sw, up_cmd, tick, start, mon_on} = 8'h00;
    gnd_n = 1'b1;
    slow_n = 1'b1;
    cyc(1);
    check_bit("reset inject enable", 1'b1, inj_n);
    check_bit("reset warn", 1'b0, warn);
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    // Coded output edges come only on the 1 MHz strobe
    v = code;
    n = 0;
    while (code === v && n < 300) begin cyc(1); n++; end
    v = code;
    n = 0;
    while (code === v && n < 300) begin cyc(1); n++; end
    check_num("strobe spacing", 100, 100, n);
    cyc(50);
    v = code;
    cmd_nrz = 1'b1;
    cyc(200);
    check_bit("one bit phase", !v, code);
    cmd_nrz = 1'b0;
    cyc(200);
    check_bit("zero bit phase", v, code);
    n = 0;
    repeat (400) begin cyc(1); n += (code === 1'b1); end
    check_num("code duty", 200, 200, n);
    // Routing table
    for (int r = 0; r < 4; r++) begin
      gnd_n = rows[r][2];
      mode_sw = rows[r][3];
      cyc(2);
      mode_sw = 1'b0;
      cyc(3);
      check_bit("inject enable", rows[r][1], inj_n);
      check_bit("upstream enable", rows[r][0], up_n);
    end
    gnd_n = 1'b1;
    // Lamps held by retriggers, dropping after the last one
    for (int w = 0; w < 3; w++) begin
      for (int i = 0; i < 10; i++) begin
        mon_on = (w == 0);
        up_cmd = (w == 1) ? !up_cmd : 1'b0;
        busy = (w == 2) ? !busy : 1'b0;
        cyc(20);
        check_bit("lamp lit", 1'b1, w == 0 ? mon_lamp : w == 1 ? up_lamp : inj_lamp);
      end
      {mon_on, up_cmd, busy} = 3'b000;
      cyc(70);
      check_bit("lamp dark", 1'b0, w == 0 ? mon_lamp : w == 1 ? up_lamp : inj_lamp);
    end
    fork
      begin : timeout_run
        int m;
        repeat (16) begin tick = 1'b1; cyc(1); tick = 1'b0; cyc(1); end
        cyc(2);
        check_bit("inject lamp stage", 1'b1, mode_lamp);
        tick = 1'b1;
        m = 0;
        while (warn !== 1'b1 && m < 60000) begin cyc(1); m++; end
        check_num("warn delay", 53220, 57380, m + 16);
        cyc(40);
        check_bit("warn tone held", 1'b1, warn);
        cyc(20);
        check_bit("warn tone over", 1'b0, warn);
        m = 60;
        while (inj_n !== 1'b1 && m < 9000) begin cyc(1); m++; end
        check_num("revert delay", 8180, 8204, m);
        cyc(3);
        check_bit("revert tone", 1'b1, revert);
        check_bit("upstream back", 1'b0, up_n);
        check_bit("inject lamp off", 1'b0, mode_lamp);
        tick = 1'b0;
      end
      begin : endpoint_run
        int k;
        logic e;
        slow_n = 1'b0;
        cyc(2);
        k = 0;
        e = ep_clk;
        repeat (200) begin cyc(1); k += (ep_clk !== e); e = ep_clk; end
        check_num("endpoint clock edges", 20, 20, k);
        cmd_nrz = 1'b1;
        cyc(3);
        check_bit("endpoint merge", 1'b1, ep_cmd);
        cmd_nrz = 1'b0;
        start = 1'b1;
        cyc(1);
        check_bit("time base clear", 1'b1, tbc);
        start = 1'b0;
        k = 1;
        while (ep_cmd !== 1'b0 && k < 10) begin cyc(1); k++; end
        while (ep_cmd !== 1'b1 && k < 33000) begin cyc(1); k++; end
        check_num("request delay", 31980, 32020, k);
        // Eight bits at 200 kHz span 40 us, 80 cycles with the short microsecond
        cyc(60);
        check_bit("request burst", 1'b1, ep_cmd);
        cyc(40);
        check_bit("request burst end", 1'b0, ep_cmd);
      end
    join
    end_sim;
  end
endmodule : testbench
